// File: hw/lcv_pkg.sv
// Package: offsets, reset values and widths for the loop counter and vector registers
`default_nettype none
package lcv_pkg;
   localparam int          LCV_DATA_W      = 16;           // Register width
   localparam int          LCV_ADDR_W      = 4;            // Register address width
   localparam logic [3:0]  LCV_IDX_VECTOR  = 4'h2;         // Handler vector address
   localparam logic [3:0]  LCV_IDX_LOOP_A  = 4'h6;         // Loop counter A
   localparam logic [3:0]  LCV_IDX_LOOP_B  = 4'h7;         // Loop counter B
   localparam logic [15:0] LCV_RST_LOOP    = 16'h0000;     // Loop counter reset value
   localparam logic [15:0] LCV_RST_VECTOR  = 16'h07fd;     // Handler vector reset value
   localparam logic [15:0] LCV_DEC_STEP    = 16'h0001;     // Decrement per loop pass
   localparam logic [15:0] LCV_RD_UNMAPPED = 16'h0000;     // Read value of unused offsets
   // Call sequencer states
   typedef enum logic [1:0] {
      LCV_ST_IDLE = 2'b00,
      LCV_ST_CALL = 2'b01,
      LCV_ST_WAIT = 2'b10
   } lcv_state_t;
endpackage
`default_nettype wire

// File: hw/lcv_loop_counter.sv
// One loop counter with software load and automatic decrement
`default_nettype none
module lcv_loop_counter
   import lcv_pkg::*;
#(
   parameter int W = LCV_DATA_W                  // Counter width
) (
   input  wire logic         ref_clk,            // Core clock
   input  wire logic         rst_n,              // Asynchronous reset, active low
   input  wire logic         load,               // Software write
   input  wire logic [W-1:0] load_data,          // Value written
   input  wire logic         dec,                // Loop pass completed
   output logic      [W-1:0] count,              // Current count
   output logic              is_zero             // Count equals zero
);
   logic [W-1:0] cnt_reg;                        // Count register
   logic [W-1:0] cnt_next;                       // Next count

   // Next count: write wins over decrement
   always_comb begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = load_data;
      end else if (dec) begin
         cnt_next = cnt_reg - LCV_DEC_STEP[W-1:0];
      end
   end

   // Count register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= LCV_RST_LOOP[W-1:0];
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign count   = cnt_reg;
   assign is_zero = (cnt_reg == '0);
endmodule
`default_nettype wire

// File: hw/lcv_regs.sv
// Loop counters, handler vector register and hardware call request
//
// Our own choice: the address-and-strobe port.
`default_nettype none
module lcv_regs
   import lcv_pkg::*;
#(
   parameter logic [15:0] VECTOR_INIT = LCV_RST_VECTOR   // Handler vector value loaded after reset; reset loads LCV_RST_VECTOR
) (
   input  wire logic                  ref_clk,          // Core clock
   input  wire logic                  rst_n,            // Asynchronous reset, active low
   input  wire logic [LCV_ADDR_W-1:0] reg_addr,         // Register index
   input  wire logic [LCV_DATA_W-1:0] reg_wdata,        // Write data
   input  wire logic                  reg_wr,           // Write strobe
   input  wire logic                  reg_rd,           // Read strobe
   output logic      [LCV_DATA_W-1:0] reg_rdata,        // Read data, cycle after strobe
   input  wire logic                  loop_dec_a,       // Sequencer: loop pass on A
   input  wire logic                  loop_dec_b,       // Sequencer: loop pass on B
   output logic      [LCV_DATA_W-1:0] loop_count_a,     // Counter A for branch logic
   output logic      [LCV_DATA_W-1:0] loop_count_b,     // Counter B for branch logic
   output logic                       loop_zero_a,      // Counter A is zero
   output logic                       loop_zero_b,      // Counter B is zero
   input  wire logic                  irq_pending,      // Enabled interrupt pending
   input  wire logic                  call_ack,         // Sequencer took the call
   output logic                       call_req,         // Hardware call request
   output logic      [LCV_DATA_W-1:0] call_target       // Address to call
);
   logic [LCV_DATA_W-1:0] vec_reg;                 // Handler vector register
   logic [LCV_DATA_W-1:0] rdata_reg;               // Read data register
   logic [LCV_DATA_W-1:0] rdata_next;              // Next read data
   logic [LCV_DATA_W-1:0] target_reg;              // Latched call target
   logic [LCV_DATA_W-1:0] target_next;             // Next call target
   lcv_state_t            state_reg;               // Call state
   lcv_state_t            state_next;              // Next call state
   logic                  wr_a;                    // Write to counter A
   logic                  wr_b;                    // Write to counter B

   // Address match helper
   function automatic logic hit(input logic [LCV_ADDR_W-1:0] a,
                                input logic [LCV_ADDR_W-1:0] idx);
      hit = (a == idx);
   endfunction

   assign wr_a = reg_wr && hit(reg_addr, LCV_IDX_LOOP_A);
   assign wr_b = reg_wr && hit(reg_addr, LCV_IDX_LOOP_B);

   // Loop counter A
   lcv_loop_counter #(.W(LCV_DATA_W)) u_loop_a (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .load      (wr_a),
      .load_data (reg_wdata),
      .dec       (loop_dec_a),
      .count     (loop_count_a),
      .is_zero   (loop_zero_a)
   );

   // Loop counter B
   lcv_loop_counter #(.W(LCV_DATA_W)) u_loop_b (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .load      (wr_b),
      .load_data (reg_wdata),
      .dec       (loop_dec_b),
      .count     (loop_count_b),
      .is_zero   (loop_zero_b)
   );

   // Vector register: read only, resets to LCV_RST_VECTOR, then holds VECTOR_INIT
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         vec_reg <= LCV_RST_VECTOR;
      end else begin
         vec_reg <= VECTOR_INIT;                   // Software writes ignored
      end
   end

   // Read mux
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd) begin
         if (hit(reg_addr, LCV_IDX_VECTOR)) begin
            rdata_next = vec_reg;
         end else if (hit(reg_addr, LCV_IDX_LOOP_A)) begin
            rdata_next = loop_count_a;
         end else if (hit(reg_addr, LCV_IDX_LOOP_B)) begin
            rdata_next = loop_count_b;
         end else begin
            rdata_next = LCV_RD_UNMAPPED;          // Unused offset
         end
      end
   end

   // Read data register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= LCV_RD_UNMAPPED;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // Call request: latch vector when an interrupt is pending
   always_comb begin
      state_next  = state_reg;
      target_next = target_reg;
      case (state_reg)
         LCV_ST_IDLE: begin
            if (irq_pending) begin
               state_next  = LCV_ST_CALL;
               target_next = vec_reg;
            end
         end
         LCV_ST_CALL: begin
            if (call_ack) begin
               state_next = LCV_ST_WAIT;           // Call taken
            end
         end
         LCV_ST_WAIT: begin
            if (!irq_pending) begin
               state_next = LCV_ST_IDLE;           // Wait for request to drop
            end
         end
         default: begin
            state_next = LCV_ST_IDLE;
         end
      endcase
   end

   // Call state registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= LCV_ST_IDLE;
         target_reg <= LCV_RST_VECTOR;
      end else begin
         state_reg  <= state_next;
         target_reg <= target_next;
      end
   end

   assign call_req    = (state_reg == LCV_ST_CALL);
   assign call_target = target_reg;
endmodule
`default_nettype wire

// File: testbench/lcv_regs_assertions.sv
// Checker for loop counters, read port and call request
`default_nettype none
module lcv_regs_assertions
   import lcv_pkg::*;
#(
   parameter logic [15:0] VECTOR_INIT = LCV_RST_VECTOR  // Vector value held after reset
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        loop_dec_a,
   input  wire logic        loop_dec_b,
   input  wire logic [15:0] loop_count_a,
   input  wire logic [15:0] loop_count_b,
   input  wire logic        loop_zero_a,
   input  wire logic        irq_pending,
   input  wire logic        call_ack,
   input  wire logic        call_req,
   input  wire logic [15:0] call_target
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Software writes to each counter
   wire wa = reg_wr && reg_addr == LCV_IDX_LOOP_A;
   wire wb = reg_wr && reg_addr == LCV_IDX_LOOP_B;
   // Call taken by the sequencer
   sequence s_ack; call_req && call_ack; endsequence
   a_rst_clear: assert property ($rose(rst_n) |-> loop_count_a == 16'h0000
      && loop_count_b == 16'h0000) else $error("counter not clear after reset");
   a_dec_a: assert property (loop_dec_a && !wa |=> loop_count_a ==
      $past(loop_count_a) - 16'h0001) else $error("counter a step wrong");
   a_dec_b: assert property (loop_dec_b && !wb |=> loop_count_b ==
      $past(loop_count_b) - 16'h0001) else $error("counter b step wrong");
   a_write_wins: assert property (wa |=> loop_count_a == $past(reg_wdata))
      else $error("write lost");
   a_hold_b: assert property (!loop_dec_b && !wb |=> $stable(loop_count_b))
      else $error("counter b moved");
   a_zero_flag: assert property (loop_zero_a == (loop_count_a == 16'h0000))
      else $error("zero flag wrong");
   a_read_back: assert property (reg_rd && reg_addr == LCV_IDX_LOOP_B |=>
      reg_rdata == $past(loop_count_b)) else $error("read data wrong");
   a_call_rise: assert property ($rose(irq_pending) && !call_req |=> call_req)
      else $error("no call");
   a_call_target: assert property (call_req |-> call_target == VECTOR_INIT)
      else $error("call target wrong");
   a_call_drop: assert property (s_ack |=> !call_req)
      else $error("call held after ack");
endmodule
bind lcv_regs lcv_regs_assertions #(.VECTOR_INIT(VECTOR_INIT)) i_chk (.ref_clk, .rst_n,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .loop_dec_a, .loop_dec_b,
   .loop_count_a, .loop_count_b, .loop_zero_a, .irq_pending, .call_ack, .call_req,
   .call_target);
`default_nettype wire

// File: testbench/lcv_seq_model.sv
// Sequencer stand-in: accepts call requests promptly or after a delay
`default_nettype none
module lcv_seq_model (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic slow,
   input  wire logic call_req,
   output logic      call_ack
);
   logic [2:0] dly_reg;  // Cycles the request has waited
   // One ack pulse per request, late when slow
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_reg  <= 3'h0;
         call_ack <= 1'b0;
      end else begin
         call_ack <= call_req && !call_ack && (!slow || dly_reg == 3'h4);
         dly_reg  <= (call_req && !call_ack) ? dly_reg + 3'h1 : 3'h0;
      end
   end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Top bench: register traffic, loop passes and call handshake against a model
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top import lcv_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, da = 0, db = 0, irq = 0, slow = 0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, ca, cb, tgt;
   logic za, zb, req, ack;
   logic [31:0] x = 32'd44, r;
   int n_mismatch = 0, n_tests = 0, ma = 0, mb = 0, cyc = 0;
   initial forever #2.5 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs();
      x ^= x << 13; x ^= x >> 17; x ^= x << 5;
      return x;
   endfunction
   lcv_regs i_dut (.ref_clk, .rst_n, .reg_addr(addr), .reg_wdata(wdata), .reg_wr, .reg_rd,
      .reg_rdata(rdata), .loop_dec_a(da), .loop_dec_b(db), .loop_count_a(ca),
      .loop_count_b(cb), .loop_zero_a(za), .loop_zero_b(zb), .irq_pending(irq),
      .call_ack(ack), .call_req(req), .call_target(tgt));
   lcv_seq_model i_seq (.ref_clk, .rst_n, .slow, .call_req(req), .call_ack(ack));
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk); reg_wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge ref_clk); reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk); reg_rd <= 1'b1; addr <= a;
      @(posedge ref_clk); reg_rd <= 1'b0;
      @(negedge ref_clk); `CHK("reg_rdata", e, rdata)
   endtask
   task automatic wrap_up();
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge ref_clk) if (++cyc == 20000) begin n_mismatch++; wrap_up(); end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(4'h6, 16'h0000);
      rd(4'h7, 16'h0000);
      rd(4'h2, 16'h07fd);
      wr(4'h2, 16'h1234);
      rd(4'h2, 16'h07fd);
      rd(4'h3, 16'h0000); // Unmapped index reads zero
      // Random writes and loop passes, small values so zero and wrap occur
      for (int i = 0; i < 400; i++) begin
         r = xs();
         @(posedge ref_clk);
         reg_wr <= r[0]; addr <= r[1] ? 4'h6 : 4'h7; wdata <= {14'h0, r[3:2]};
         da <= r[4]; db <= r[5];
         @(negedge ref_clk);
         `CHK("loop_count_a", ma[15:0], ca)
         `CHK("loop_count_b", mb[15:0], cb)
         `CHK("loop_zero_a", ma == 0, za)
         `CHK("loop_zero_b", mb == 0, zb)
         if (r[0] && r[1]) ma = r[3:2]; else if (r[4]) ma = (ma - 1) & 'hffff;
         if (r[0] && !r[1]) mb = r[3:2]; else if (r[5]) mb = (mb - 1) & 'hffff;
      end
      @(posedge ref_clk); reg_wr <= 1'b0; da <= 1'b0; db <= 1'b0;
      rd(4'h6, ma[15:0]);
      rd(4'h7, mb[15:0]);
      // Call handshake, prompt then slow acceptance
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk); slow <= k[0]; irq <= 1'b1;
         @(posedge ref_clk); @(negedge ref_clk);
         `CHK("call_req", 1'b1, req)
         `CHK("call_target", 16'h07fd, tgt)
         repeat (8) @(posedge ref_clk);
         @(negedge ref_clk);
         `CHK("call_req", 1'b0, req)
         irq <= 1'b0; repeat (2) @(posedge ref_clk);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
